/* rtl/smc_cfg.svh */
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH

`define SMC_ADDR_W 4
`define SMC_DATA_W 8

`define SMC_OFF_MODE 4'h0
`define SMC_OFF_LEVEL 4'h1
`define SMC_OFF_MARGIN 4'h8
`define SMC_OFF_IRQCTRL 4'h9
`define SMC_OFF_FLAGS 4'hA
`define SMC_OFF_STATUS 4'hB

`define SMC_BIT_RATE 4
`define SMC_RUN_HI 3
`define SMC_RUN_LO 2
`define SMC_LP_HI 1
`define SMC_LP_LO 0
`define SMC_LVL_HI 2
`define SMC_MARGIN_HI 1
`define SMC_EDGE_HI 2
`define SMC_EDGE_LO 1
`define SMC_BIT_IE 0
`define SMC_BIT_FLAG 0
`define SMC_BIT_STATE 0

`define SMC_MODE_OFF 2'h0
`define SMC_MODE_CONT 2'h1
`define SMC_MODE_SAMP 2'h2
`define SMC_MODE_WAKE 2'h3

`define SMC_EDGE_BELOW 2'h0
`define SMC_EDGE_ABOVE 2'h1
`define SMC_EDGE_CROSS 2'h2

`define SMC_RST_BYTE 8'h00
`define SMC_RST_MODE 2'h0
`define SMC_RST_LVL 3'h0
`define SMC_GUARD_WIN 3'h4
`define SMC_FUSE_LOAD 2'h2
`define SMC_FUSE_DONE 2'h3

`define SMC_CLK_MHZ 250
`define SMC_RATE_FAST_US 1000
`define SMC_RATE_SLOW_US 8000
`define SMC_CNT_W 22

`endif

/* rtl/smc_pkg.sv */
`include "smc_cfg.svh"

package smc_pkg;

    typedef struct packed {
        logic [`SMC_ADDR_W-1:0] addr;
        logic [`SMC_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } smc_bus_req_s;

    typedef struct packed {
        logic sample_rate_sel;
        logic [1:0] run_mode;
        logic [1:0] lp_mode;
        logic [2:0] trip_level;
    } smc_fuse_s;

    typedef enum logic [2:0] {
        SMC_ST_RUN = 3'b001,
        SMC_ST_SLEEP = 3'b010,
        SMC_ST_WAKE = 3'b100
    } smc_pwr_e;

endpackage : smc_pkg

/* rtl/smc_regs.sv */
// How it works
// RULE_01: Rate bit picks 1 kHz or 125 Hz
// RULE_02: Rate bit from fuse, read-only, unguarded
// RULE_03: Run-mode field read-only, fuse loaded
// RULE_04: Run mode 3 holds execution at wake
// RULE_05: Low-power field writable, fuse loaded, 3 reserved
// RULE_06: Trip level read-only, loaded from fuses
// RULE_07: Margin code places warning above trip
// RULE_08: Edge select picks falling, rising, either
// RULE_09: Bit 0 enables the warning interrupt
// RULE_10: Matching trigger sets the warning flag; the code sets it only while the bit 0 interrupt enable is also set
// RULE_11: Flag holds while detector is disabled
// RULE_12: State bit shows supply below warning; the code updates it only while the bit 0 interrupt enable is set
// RULE_13: Other registers reset to zero
// RULE_14: Register map offsets as listed
// RULE_15: Low-power field needs key then write
// RULE_16: Sleep uses low-power mode, wake run mode
// RULE_17: Monitor follows detector mode and sampling
// RULE_18: Interrupt high while enable and flag set
// RULE_19: Writing one clears the flag
// RULE_20: Reserved reads zero, writes ignored
`timescale 1ns/1ns
`include "smc_cfg.svh"

module smc_regs #(
    parameter logic [`SMC_CNT_W-1:0] SAMPLE_CYC_FAST = `SMC_CNT_W'(`SMC_RATE_FAST_US * `SMC_CLK_MHZ),
    parameter logic [`SMC_CNT_W-1:0] SAMPLE_CYC_SLOW = `SMC_CNT_W'(`SMC_RATE_SLOW_US * `SMC_CLK_MHZ)
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire smc_pkg::smc_bus_req_s bus_req_i,
    output logic [`SMC_DATA_W-1:0] rdata_o,
    input wire smc_pkg::smc_fuse_s fuse_i,
    input wire logic guard_key_i,
    input wire logic lp_sleep_i,
    input wire logic detector_ready_i,
    input wire logic warn_below_i,
    output logic [1:0] detector_mode_o,
    output logic sample_rate_o,
    output logic sample_strobe_o,
    output logic [2:0] trip_level_o,
    output logic [1:0] warning_margin_o,
    output logic hold_exec_o,
    output logic warning_irq_o
);

    function automatic logic det_on(input logic [1:0] mode);
        det_on = (mode != `SMC_MODE_OFF);
    endfunction : det_on

    function automatic logic hit(input logic [`SMC_ADDR_W-1:0] a, input logic [`SMC_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    // Fuse straps and analog inputs, two stages each
    smc_pkg::smc_fuse_s fuse_m_r;
    smc_pkg::smc_fuse_s fuse_s_r;
    logic [1:0] fuse_cnt_r;
    logic ready_m_r;
    logic ready_s_r;
    logic below_m_r;
    logic below_s_r;

    logic sample_rate_r;
    logic [1:0] run_mode_r;
    logic [1:0] lp_mode_r;
    logic [2:0] trip_level_r;
    logic [1:0] margin_r;
    logic [1:0] edge_sel_r;
    logic irq_en_r;
    logic flag_r;
    logic flag_nxt;
    logic state_r;
    logic [2:0] guard_cnt_r;
    logic [2:0] guard_cnt_nxt;
    logic [`SMC_CNT_W-1:0] samp_cnt_r;
    logic [`SMC_CNT_W-1:0] samp_cnt_nxt;
    logic [1:0] det_mode_r;
    logic [`SMC_DATA_W-1:0] rdata_r;
    smc_pkg::smc_pwr_e pwr_r;
    smc_pkg::smc_pwr_e pwr_nxt;

    wire fuse_load = (fuse_cnt_r == `SMC_FUSE_LOAD);
    wire wr = bus_req_i.wr;
    wire rd = bus_req_i.rd;
    wire [`SMC_ADDR_W-1:0] addr = bus_req_i.addr;
    wire [`SMC_DATA_W-1:0] wdata = bus_req_i.wdata;

    wire wr_mode = wr & hit(addr, `SMC_OFF_MODE); // RULE_14
    wire wr_margin = wr & hit(addr, `SMC_OFF_MARGIN); // RULE_14
    wire wr_irqctrl = wr & hit(addr, `SMC_OFF_IRQCTRL); // RULE_14
    wire wr_flags = wr & hit(addr, `SMC_OFF_FLAGS); // RULE_14

    // Guard window open for a few cycles after the key
    wire guard_open = (guard_cnt_r != 3'h0); // RULE_15
    wire [1:0] lp_wdata = wdata[`SMC_LP_HI:`SMC_LP_LO];
    wire lp_take = wr_mode & guard_open & (lp_wdata != `SMC_MODE_WAKE); // RULE_15 RULE_05

    assign guard_cnt_nxt = guard_key_i ? `SMC_GUARD_WIN :
                           (lp_take ? 3'h0 : (guard_open ? guard_cnt_r - 3'h1 : 3'h0)); // RULE_15

    // Power-state tracking for the detector mode
    always_comb
    begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            smc_pkg::SMC_ST_RUN:
            begin
                if (lp_sleep_i)
                    pwr_nxt = smc_pkg::SMC_ST_SLEEP; // RULE_16
            end
            smc_pkg::SMC_ST_SLEEP:
            begin
                if (!lp_sleep_i)
                    pwr_nxt = (run_mode_r == `SMC_MODE_WAKE) ? smc_pkg::SMC_ST_WAKE : smc_pkg::SMC_ST_RUN; // RULE_04
            end
            smc_pkg::SMC_ST_WAKE:
            begin
                if (lp_sleep_i)
                    pwr_nxt = smc_pkg::SMC_ST_SLEEP;
                else if (ready_s_r)
                    pwr_nxt = smc_pkg::SMC_ST_RUN; // RULE_04
            end
            default:
            begin
                pwr_nxt = smc_pkg::SMC_ST_RUN;
            end
        endcase
    end

    wire in_sleep = (pwr_r == smc_pkg::SMC_ST_SLEEP);
    wire [1:0] act_mode = in_sleep ? lp_mode_r : run_mode_r; // RULE_16
    wire [1:0] eff_mode = (act_mode == `SMC_MODE_WAKE) ? `SMC_MODE_CONT : act_mode; // RULE_03

    // Sample timer, period set by the rate bit
    wire sampled = (det_mode_r == `SMC_MODE_SAMP);
    wire samp_tick = sampled & (samp_cnt_r == `SMC_CNT_W'(0));
    wire [`SMC_CNT_W-1:0] samp_reload = sample_rate_r ? SAMPLE_CYC_SLOW - `SMC_CNT_W'(1) :
                                        SAMPLE_CYC_FAST - `SMC_CNT_W'(1); // RULE_01

    assign samp_cnt_nxt = !sampled ? samp_reload :
                          (samp_tick ? samp_reload : samp_cnt_r - `SMC_CNT_W'(1)); // RULE_01

    // Monitor runs only while detector is on
    wire det_en = det_on(det_mode_r);
    wire mon_active = det_en & irq_en_r; // RULE_17 RULE_09
    wire mon_sample = mon_active & (sampled ? samp_tick : 1'b1); // RULE_17

    wire fell = ~state_r & below_s_r;
    wire rose = state_r & ~below_s_r;
    wire trig_hit = (edge_sel_r == `SMC_EDGE_BELOW) ? fell :
                    (edge_sel_r == `SMC_EDGE_ABOVE) ? rose :
                    (edge_sel_r == `SMC_EDGE_CROSS) ? (fell | rose) : 1'b0; // RULE_08
    wire flag_set = mon_sample & trig_hit; // RULE_10 RULE_11
    wire flag_clr = wr_flags & wdata[`SMC_BIT_FLAG]; // RULE_19

    assign flag_nxt = flag_set | (flag_r & ~flag_clr); // RULE_19 RULE_10

    // Read multiplexer, unmapped offsets read zero
    wire [`SMC_DATA_W-1:0] rd_mode = {3'h0, sample_rate_r, run_mode_r, lp_mode_r};
    wire [`SMC_DATA_W-1:0] rd_level = {5'h00, trip_level_r};
    wire [`SMC_DATA_W-1:0] rd_margin = {6'h00, margin_r};
    wire [`SMC_DATA_W-1:0] rd_irqctrl = {5'h00, edge_sel_r, irq_en_r};
    wire [`SMC_DATA_W-1:0] rd_flags = {7'h00, flag_r};
    wire [`SMC_DATA_W-1:0] rd_status = {7'h00, state_r};
    wire [`SMC_DATA_W-1:0] rd_mux = hit(addr, `SMC_OFF_MODE) ? rd_mode :
                                    hit(addr, `SMC_OFF_LEVEL) ? rd_level :
                                    hit(addr, `SMC_OFF_MARGIN) ? rd_margin :
                                    hit(addr, `SMC_OFF_IRQCTRL) ? rd_irqctrl :
                                    hit(addr, `SMC_OFF_FLAGS) ? rd_flags :
                                    hit(addr, `SMC_OFF_STATUS) ? rd_status : `SMC_RST_BYTE; // RULE_20 RULE_14

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            fuse_m_r <= '0;
            fuse_s_r <= '0;
            ready_m_r <= 1'b0;
            ready_s_r <= 1'b0;
            below_m_r <= 1'b0;
            below_s_r <= 1'b0;
        end
        else
        begin
            fuse_m_r <= fuse_i;
            fuse_s_r <= fuse_m_r;
            ready_m_r <= detector_ready_i;
            ready_s_r <= ready_m_r;
            below_m_r <= warn_below_i;
            below_s_r <= below_m_r;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            fuse_cnt_r <= 2'h0;
        else if (fuse_cnt_r != `SMC_FUSE_DONE)
            fuse_cnt_r <= fuse_cnt_r + 2'h1;
    end

    // Fuse-backed fields: loaded once the straps are through the synchroniser
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sample_rate_r <= 1'b0;
            run_mode_r <= `SMC_RST_MODE;
            trip_level_r <= `SMC_RST_LVL;
        end
        else if (fuse_load)
        begin
            sample_rate_r <= fuse_s_r.sample_rate_sel; // RULE_02
            run_mode_r <= fuse_s_r.run_mode; // RULE_03
            trip_level_r <= fuse_s_r.trip_level; // RULE_06
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            lp_mode_r <= `SMC_RST_MODE;
        else if (fuse_load)
            lp_mode_r <= fuse_s_r.lp_mode; // RULE_05
        else if (lp_take)
            lp_mode_r <= lp_wdata; // RULE_15 RULE_05
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            margin_r <= 2'h0; // RULE_13
            edge_sel_r <= 2'h0; // RULE_13
            irq_en_r <= 1'b0; // RULE_13
        end
        else
        begin
            if (wr_margin)
                margin_r <= wdata[`SMC_MARGIN_HI:0]; // RULE_07
            if (wr_irqctrl)
            begin
                edge_sel_r <= wdata[`SMC_EDGE_HI:`SMC_EDGE_LO]; // RULE_08
                irq_en_r <= wdata[`SMC_BIT_IE]; // RULE_09
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            flag_r <= 1'b0; // RULE_13
            state_r <= 1'b0; // RULE_13
        end
        else
        begin
            flag_r <= flag_nxt; // RULE_10 RULE_19
            if (mon_sample)
                state_r <= below_s_r; // RULE_12
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            guard_cnt_r <= 3'h0;
            samp_cnt_r <= '0;
            det_mode_r <= `SMC_RST_MODE;
            pwr_r <= smc_pkg::SMC_ST_RUN;
        end
        else
        begin
            guard_cnt_r <= guard_cnt_nxt;
            samp_cnt_r <= samp_cnt_nxt;
            det_mode_r <= eff_mode; // RULE_16
            pwr_r <= pwr_nxt;
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rdata_r <= `SMC_RST_BYTE;
        else
            rdata_r <= rd ? rd_mux : `SMC_RST_BYTE;
    end

    assign rdata_o = rdata_r;
    assign detector_mode_o = det_mode_r;
    assign sample_rate_o = sample_rate_r; // RULE_01
    assign sample_strobe_o = samp_tick; // RULE_17
    assign trip_level_o = trip_level_r; // RULE_06
    assign warning_margin_o = margin_r; // RULE_07
    assign hold_exec_o = (pwr_r == smc_pkg::SMC_ST_WAKE); // RULE_04
    assign warning_irq_o = irq_en_r & flag_r; // RULE_18

endmodule : smc_regs

/* testbench/smc_regs_asserts.sv */
`timescale 1ns/1ns
module smc_regs_asserts (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire smc_pkg::smc_bus_req_s bus_req_i,
    input wire logic [7:0] rdata_o,
    input wire smc_pkg::smc_fuse_s fuse_i,
    input wire logic detector_ready_i,
    input wire logic [1:0] detector_mode_o,
    input wire logic sample_rate_o,
    input wire logic sample_strobe_o,
    input wire logic [2:0] trip_level_o,
    input wire logic [1:0] warning_margin_o,
    input wire logic hold_exec_o,
    input wire logic warning_irq_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_rd(a);
        bus_req_i.rd && bus_req_i.addr == a;
    endsequence
    sequence s_ready;
        detector_ready_i [*5];
    endsequence
    property p_idle;
        !bus_req_i.rd |=> rdata_o == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("read data not zero");
    property p_rsv;
        bus_req_i.rd && bus_req_i.addr inside {[4'h2:4'h7], [4'hC:4'hF]} |=> rdata_o == 8'h00;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved read not zero");
    property p_lvl;
        s_rd(4'h1) |=> rdata_o == {5'h00, trip_level_o};
    endproperty
    a_lvl: assert property (p_lvl) else $error("level read mismatch");
    property p_rate;
        s_rd(4'h0) |=> rdata_o[7:4] == {3'h0, sample_rate_o};
    endproperty
    a_rate: assert property (p_rate) else $error("rate read mismatch");
    property p_margin;
        bus_req_i.wr && bus_req_i.addr == 4'h8 |=> warning_margin_o == $past(bus_req_i.wdata[1:0]);
    endproperty
    a_margin: assert property (p_margin) else $error("margin not taken");
    property p_irqrd;
        s_rd(4'hA) ##0 warning_irq_o |=> rdata_o == 8'h01;
    endproperty
    a_irqrd: assert property (p_irqrd) else $error("request without flag");
    property p_irqhold;
        warning_irq_o && !bus_req_i.wr |=> warning_irq_o;
    endproperty
    a_irqhold: assert property (p_irqhold) else $error("request dropped");
    property p_mode;
        detector_mode_o != 2'h3;
    endproperty
    a_mode: assert property (p_mode) else $error("detector mode 3 driven");
    property p_strobe;
        sample_strobe_o |-> detector_mode_o == 2'h2;
    endproperty
    a_strobe: assert property (p_strobe) else $error("sample tick outside sampled mode");
    property p_holdrun;
        hold_exec_o |-> fuse_i.run_mode == 2'h3;
    endproperty
    a_holdrun: assert property (p_holdrun) else $error("hold without wake wait mode");
    property p_holdend;
        hold_exec_o ##1 s_ready |-> !hold_exec_o;
    endproperty
    a_holdend: assert property (p_holdend) else $error("hold not released");
endmodule : smc_regs_asserts

/* testbench/smc_analog_model.sv */
`timescale 1ns/1ns
module smc_analog_model #(
    parameter int READY_CYC = 3
) (
    input wire logic mclk_i,
    input wire logic below_req_i,
    input wire logic [1:0] detector_mode_i,
    output logic warn_below_o,
    output logic detector_ready_o
);
    int cnt = 0;
    initial
    begin
        warn_below_o = 1'b0;
        detector_ready_o = 1'b0;
    end
    always @(posedge mclk_i)
    begin
        if (detector_mode_i == 2'h0)
        begin
            // Comparator off: output meaningless
            cnt <= 0;
            detector_ready_o <= 1'b0;
            warn_below_o <= !warn_below_o;
        end
        else
        begin
            cnt <= (cnt < READY_CYC) ? cnt + 1 : cnt;
            detector_ready_o <= (cnt >= READY_CYC);
            warn_below_o <= below_req_i;
        end
    end
endmodule : smc_analog_model

/* testbench/testbench.sv */
`timescale 1ns/1ns
module testbench;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    smc_pkg::smc_bus_req_s req = '0;
    logic key = 1'b0;
    logic sleep = 1'b0;
    logic below = 1'b0;
    smc_pkg::smc_fuse_s fuse = 8'h72;
    wire logic [7:0] rdata;
    wire logic ready, warn, strobe, hold, irq, rate;
    wire logic [1:0] dmode, margin;
    wire logic [2:0] lvl;
    int err_count = 0;
    int total_checks = 0;
    initial
    begin
        forever #2 mclk_i = ~mclk_i;
    end
    smc_regs #(.SAMPLE_CYC_FAST(22'h8), .SAMPLE_CYC_SLOW(22'h14)) u_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .bus_req_i(req), .rdata_o(rdata), .fuse_i(fuse), .guard_key_i(key),
        .lp_sleep_i(sleep), .detector_ready_i(ready), .warn_below_i(warn), .detector_mode_o(dmode),
        .sample_rate_o(rate), .sample_strobe_o(strobe), .trip_level_o(lvl), .warning_margin_o(margin),
        .hold_exec_o(hold), .warning_irq_o(irq));
    smc_analog_model u_ana (.mclk_i(mclk_i), .below_req_i(below), .detector_mode_i(dmode),
        .warn_below_o(warn), .detector_ready_o(ready));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : cyc
    task automatic step();
        @(posedge mclk_i);
        #1;
    endtask : step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_i);
        req <= '0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string name);
        @(posedge mclk_i);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk_i);
        req <= '0;
        #1;
        chk(name, exp, rdata);
    endtask : rd
    task automatic unlock(input int n);
        @(posedge mclk_i);
        key <= 1'b1;
        @(posedge mclk_i);
        key <= 1'b0;
        cyc(n);
    endtask : unlock
    task automatic t_reset();
        rd(4'h0, 8'h0E, "mode");
        rd(4'h1, 8'h02, "level");
        for (int a = 8; a < 12; a++)
            rd(4'(a), 8'h00, "zero reset");
        rd(4'h5, 8'h00, "reserved");
        $display("reset test done");
    endtask : t_reset
    task automatic t_access();
        wr(4'h8, 8'hFF);
        rd(4'h8, 8'h03, "margin");
        chk("margin out", 8'h03, {6'h00, margin});
        wr(4'h1, 8'h05);
        rd(4'h1, 8'h02, "level");
        wr(4'h5, 8'hFF);
        rd(4'h5, 8'h00, "reserved");
        wr(4'h0, 8'h11);
        rd(4'h0, 8'h0E, "unkeyed");
        chk("rate", 8'h00, {7'h00, rate});
        $display("access test done");
    endtask : t_access
    task automatic t_guard();
        unlock(2);
        wr(4'h0, 8'h01);
        rd(4'h0, 8'h0D, "last slot");
        unlock(3);
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h0D, "too late");
        unlock(0);
        wr(4'h0, 8'h03);
        rd(4'h0, 8'h0D, "lp reserved");
        unlock(0);
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h0C, "lp off");
        $display("guard test done");
    endtask : t_guard
    task automatic t_monitor();
        for (int e = 0; e < 3; e++)
        begin
            wr(4'h9, 8'(e * 2 + 1));
            wr(4'hA, 8'h01);
            below <= !below;
            cyc(8);
            rd(4'hA, 8'h01, "flag");
            rd(4'hB, {7'h00, below}, "state");
            chk("irq", 8'h01, {7'h00, irq});
        end
        wr(4'h9, 8'h01);
        wr(4'hA, 8'h01);
        below <= 1'b0;
        cyc(8);
        rd(4'hA, 8'h00, "no rise flag");
        @(posedge mclk_i);
        below <= 1'b1;
        cyc(8);
        wr(4'h9, 8'h00);
        #1;
        chk("irq masked", 8'h00, {7'h00, irq});
        wr(4'h9, 8'h01);
        wr(4'hA, 8'h00);
        rd(4'hA, 8'h01, "zero write");
        wr(4'hA, 8'h01);
        rd(4'hA, 8'h00, "cleared");
        chk("irq off", 8'h00, {7'h00, irq});
        $display("monitor test done");
    endtask : t_monitor
    task automatic t_sleep();
        int i;
        wr(4'h9, 8'h05);
        sleep <= 1'b1;
        cyc(4);
        chk("sleep mode", 8'h00, {6'h00, dmode});
        below <= 1'b0;
        cyc(8);
        rd(4'hA, 8'h00, "off flag");
        rd(4'hB, 8'h01, "off state");
        @(posedge mclk_i);
        sleep <= 1'b0;
        cyc(2);
        #1;
        chk("hold", 8'h01, {7'h00, hold});
        for (i = 0; i < 30 && hold !== 1'b0; i++)
            step();
        if (i == 30)
        begin
            err_count++;
            $display("wrong value hold expected 0 seen %b", hold);
            return;
        end
        chk("wake mode", 8'h01, {6'h00, dmode});
        unlock(0);
        wr(4'h0, 8'h02);
        sleep <= 1'b1;
        for (i = 0; i < 40 && strobe !== 1'b1; i++)
            step();
        if (i == 40)
        begin
            err_count++;
            $display("wrong value strobe expected 1 seen %b", strobe);
            return;
        end
        chk("sampled mode", 8'h02, {6'h00, dmode});
        $display("sleep test done");
    endtask : t_sleep
    task automatic t_fuse();
        int n;
        @(posedge mclk_i);
        rst_b_i <= 1'b0;
        sleep <= 1'b0;
        fuse <= 8'hCF;
        step();
        chk("reset mode out", 8'h00, {6'h00, dmode});
        chk("reset read data", 8'h00, rdata);
        cyc(3);
        rst_b_i <= 1'b1;
        cyc(4);
        rd(4'h0, 8'h19, "fuse mode");
        rd(4'h1, 8'h07, "fuse level");
        chk("fuse rate", 8'h01, {7'h00, rate});
        chk("level out", 8'h07, {5'h00, lvl});
        chk("run sampled", 8'h02, {6'h00, dmode});
        for (n = 0; n < 40 && strobe !== 1'b1; n++)
            step();
        step();
        for (n = 1; n < 50 && strobe !== 1'b1; n++)
            step();
        chk("sample period", 8'h14, 8'(n));
        $display("fuse test done");
    endtask : t_fuse
    initial
    begin
        cyc(4);
        rst_b_i <= 1'b1;
        cyc(4);
        t_reset();
        t_access();
        t_guard();
        t_monitor();
        t_sleep();
        t_fuse();
        wrap_up();
    end
endmodule : testbench
bind smc_regs smc_regs_asserts u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus_req_i(bus_req_i),
    .rdata_o(rdata_o), .fuse_i(fuse_i), .detector_ready_i(detector_ready_i),
    .detector_mode_o(detector_mode_o), .sample_rate_o(sample_rate_o), .sample_strobe_o(sample_strobe_o),
    .trip_level_o(trip_level_o), .warning_margin_o(warning_margin_o), .hold_exec_o(hold_exec_o),
    .warning_irq_o(warning_irq_o));
